/* File: src/tst_pkg.sv */
package tst_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_CTRL_ZERO = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_TRIG      = 8'h08;
  localparam logic [7:0]  OFS_COUNTER   = 8'h0c;
  localparam logic [7:0]  OFS_CMP_A     = 8'h10;
  localparam logic [7:0]  OFS_CMP_B     = 8'h14;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FLAG_HI   = 7;   // match_b, match_a, wrap at 7:5
  localparam int FLAG_LO   = 5;
  localparam int ST_RSV    = 4;
  localparam int OS_B_HI   = 3;
  localparam int OS_B_LO   = 2;
  localparam int OS_A_HI   = 1;
  localparam int OS_A_LO   = 0;
  localparam int IEN_HI    = 7;   // match_b/a/wrap irq enables
  localparam int IEN_LO    = 5;
  localparam int CCLR_HI   = 4;
  localparam int CCLR_LO   = 3;
  localparam int CKS_HI    = 2;
  localparam int CKS_LO    = 0;
  localparam int TRS_HI    = 7;   // reserved 7:5 of trigger ctrl
  localparam int TRS_LO    = 5;
  localparam int TEDGE_HI  = 4;
  localparam int TEDGE_LO  = 3;
  localparam int TGATE     = 2;
  localparam int TRS_BIT1  = 1;
  localparam int XCLK_BIT  = 0;

  // ---------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL0_RST  = 8'h00;
  localparam logic [7:0] CMP_RST    = 8'hff;
  localparam logic [7:0] CNT_RST    = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [2:0] RSV_ONES3  = 3'h7;
  localparam logic       RSV_ONE    = 1'h1;
  localparam int         SYNC_W     = 3;  // trigger, ext clock, ext reset
  localparam int         PIN_TRIG   = 0;
  localparam int         PIN_XCLK   = 1;
  localparam int         PIN_XRST   = 2;
  localparam int         DIV_W      = 7;

  // Output select codes
  localparam logic [1:0] OS_KEEP    = 2'h0;
  localparam logic [1:0] OS_LOW     = 2'h1;
  localparam logic [1:0] OS_HIGH    = 2'h2;
  localparam logic [1:0] OS_TOGGLE  = 2'h3;

  // Trigger edge select codes
  localparam logic [1:0] EDGE_OFF   = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_FALL  = 2'h2;
  localparam logic [1:0] EDGE_BOTH  = 2'h3;

  // Counter clear source codes
  localparam logic [1:0] CCLR_NONE  = 2'h0;
  localparam logic [1:0] CCLR_A     = 2'h1;
  localparam logic [1:0] CCLR_B     = 2'h2;
  localparam logic [1:0] CCLR_PIN   = 2'h3;

  // Clock select codes
  localparam logic [2:0] CKS_OFF0   = 3'h0;
  localparam logic [2:0] CKS_OFF1   = 3'h4;
  localparam logic [2:0] CKS_XRISE  = 3'h5;
  localparam logic [2:0] CKS_XFALL  = 3'h6;
  localparam logic [2:0] CKS_XBOTH  = 3'h7;

  // AXI responses
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: src/tst_prescale.sv */
`timescale 1ns/1ps
module tst_prescale
  import tst_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  tst_tick_if.gen   tk
);

  // ---------------------------------------------------------------
  // Divider and edge history
  // ---------------------------------------------------------------
  logic [DIV_W-1:0] div_q;
  logic             tap_prev_q;
  logic             ext_prev_q;

  wire  [2:0] tap_idx  = {tk.clk_sel[1:0], tk.extra_clk_select} - 3'h1;
  wire        is_int   = ~tk.clk_sel[2] & (tk.clk_sel != CKS_OFF0);
  // Off codes pick no tap, so no unknown enters the history
  wire        tap      = is_int & div_q[tap_idx];
  wire        int_fall = tap_prev_q & ~tap;
  wire        ext_rise = ~ext_prev_q & tk.ext_lvl;
  wire        ext_fall = ext_prev_q & ~tk.ext_lvl;

  // Switching taps can look like a falling edge and count once
  assign tk.tick = is_int                    ? int_fall :
                   (tk.clk_sel == CKS_XRISE) ? ext_rise :
                   (tk.clk_sel == CKS_XFALL) ? ext_fall :
                   (tk.clk_sel == CKS_XBOTH) ? (ext_rise | ext_fall) :
                   1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q      <= '0;
      tap_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else if (ce) begin
      div_q      <= div_q + 1'b1;
      tap_prev_q <= tap;
      ext_prev_q <= tk.ext_lvl;
    end
  end

endmodule

/* File: src/tst_tick_if.sv */
`timescale 1ns/1ps
interface tst_tick_if;
  logic [2:0] clk_sel;
  logic       extra_clk_select;
  logic       ext_lvl;
  logic       tick;

  modport gen (input clk_sel, input extra_clk_select, input ext_lvl, output tick);
  modport use_side (output clk_sel, output extra_clk_select, output ext_lvl, input tick);
endinterface

/* File: src/tst_top.sv */
//
// Overview of operation
// - Compare flag B sets when counter equals compare constant B.
// - Compare flag A sets when counter equals compare constant A.
// - Wrap flag sets when counter rolls from all ones to zero.
// - Flags clear by writing zero only after reading them as one.
// - Status bit 4 always reads as one.
// - Match B drives waveform per select B: keep, low, high, toggle.
// - Match A drives waveform per select A with the same four codes.
// - The two output selects act independently on their own match.
// - Waveform output is low after reset until the first match.
// - Trigger edge select: off, rising, falling or both edges.
// - With gating on, counter halts at clear and resumes on trigger edge.
// - Extra clock select bit joins clock-select bits 1 to 0 to pick the divider tap.
// - Trigger register bits 7 to 5 and bit 1 read as one.
// - Clock codes: inhibit, divided system clock taps, external pin edges.
// - Interrupt requested while a flag and its enable are both one.
// - Simultaneous matches: toggle beats drive high beats drive low.
`timescale 1ns/1ps
module tst_top
  import tst_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  output wire logic [1:0]        s_axi_bresp,
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  output wire logic [31:0]       s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              trigger_pin,
  input  wire logic              ext_clk_pin,
  input  wire logic              ext_reset_pin,
  output wire logic              waveform_pin,
  output wire logic              irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]        ctrl0_q;
  logic [2:0]        flags_q;     // match_b_flag, match_a_flag, wrap_flag
  logic [2:0]        armed_q;
  logic [3:0]        os_q;
  logic [1:0]        edge_q;
  logic              gate_q;
  logic              xclk_q;
  logic [7:0]        cnt_q;
  logic [7:0]        cmp_a_q;
  logic [7:0]        cmp_b_q;
  logic              wave_q;
  logic              run_q;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] pin_prev_q;

  logic              aw_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic              w_hold_q;
  logic [7:0]        wdata_q;
  logic              wstrb0_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_CTRL_ZERO) ||
                (a == OFS_STATUS)    ||
                (a == OFS_TRIG)      ||
                (a == OFS_COUNTER)   ||
                (a == OFS_CMP_A)     ||
                (a == OFS_CMP_B);
  endfunction

  // Combined action of both matches on the waveform level
  function automatic logic wave_next(input logic cur,
                                     input logic hit_a, input logic [1:0] sel_a,
                                     input logic hit_b, input logic [1:0] sel_b);
    logic [1:0] a;
    logic [1:0] b;
    a = hit_a ? sel_a : OS_KEEP;
    b = hit_b ? sel_b : OS_KEEP;
    if (a == OS_TOGGLE || b == OS_TOGGLE) begin
      wave_next = ~cur;
    end else if (a == OS_HIGH || b == OS_HIGH) begin
      wave_next = 1'b1;
    end else if (a == OS_LOW || b == OS_LOW) begin
      wave_next = 1'b0;
    end else begin
      wave_next = cur;
    end
  endfunction

  // ---------------------------------------------------------------
  // Count source
  // ---------------------------------------------------------------
  tst_tick_if tk ();

  assign tk.clk_sel          = ctrl0_q[CKS_HI:CKS_LO];
  assign tk.extra_clk_select = xclk_q;
  assign tk.ext_lvl          = sync2_q[PIN_XCLK];

  tst_prescale u_prescale (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .tk      (tk)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire ar_fire  = s_axi_arvalid & s_axi_arready;
  wire wr_do    = aw_hold_q & w_hold_q & ~bvalid_q & ce;
  wire wr_ok    = wr_do & wstrb0_q;
  wire wr_ctrl0 = wr_ok & (awaddr_q == OFS_CTRL_ZERO);
  wire wr_stat  = wr_ok & (awaddr_q == OFS_STATUS);
  wire wr_trig  = wr_ok & (awaddr_q == OFS_TRIG);
  wire wr_cnt   = wr_ok & (awaddr_q == OFS_COUNTER);
  wire wr_cmp_a = wr_ok & (awaddr_q == OFS_CMP_A);
  wire wr_cmp_b = wr_ok & (awaddr_q == OFS_CMP_B);
  wire rd_stat  = ar_fire & (s_axi_araddr == OFS_STATUS);

  wire [7:0] stat_rd = {flags_q, RSV_ONE, os_q};
  wire [7:0] trig_rd = {RSV_ONES3, edge_q, gate_q, RSV_ONE, xclk_q};

  wire [7:0] rd_mux = (s_axi_araddr == OFS_CTRL_ZERO) ? ctrl0_q :
                      (s_axi_araddr == OFS_STATUS)    ? stat_rd :
                      (s_axi_araddr == OFS_TRIG)      ? trig_rd :
                      (s_axi_araddr == OFS_COUNTER)   ? cnt_q   :
                      (s_axi_araddr == OFS_CMP_A)     ? cmp_a_q :
                      (s_axi_araddr == OFS_CMP_B)     ? cmp_b_q : 8'h00;

  // Ready drops while frozen so no beat is taken and then lost
  assign s_axi_awready = ce & ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ce & ~w_hold_q & ~bvalid_q;
  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ---------------------------------------------------------------
  // Pin edges
  // ---------------------------------------------------------------
  wire trig_rise = sync2_q[PIN_TRIG] & ~pin_prev_q[PIN_TRIG];
  wire trig_fall = ~sync2_q[PIN_TRIG] & pin_prev_q[PIN_TRIG];
  wire xrst_rise = sync2_q[PIN_XRST] & ~pin_prev_q[PIN_XRST];
  wire trig_evt  = ((edge_q == EDGE_RISE) & trig_rise) |
                   ((edge_q == EDGE_FALL) & trig_fall) |
                   ((edge_q == EDGE_BOTH) & (trig_rise | trig_fall));

  // ---------------------------------------------------------------
  // Counter, matches and flags
  // ---------------------------------------------------------------
  wire [1:0] cclr     = ctrl0_q[CCLR_HI:CCLR_LO];
  wire       count_en = ce & tk.tick & (~gate_q | run_q);
  // Match is taken in the last cycle of equality; a compare write masks it
  wire       match_a  = count_en & (cnt_q == cmp_a_q) & ~wr_cmp_a;
  wire       match_b  = count_en & (cnt_q == cmp_b_q) & ~wr_cmp_b;
  wire       wrap     = count_en & (cnt_q == CNT_MAX);
  wire       clr_evt  = ((cclr == CCLR_A) & match_a) |
                        ((cclr == CCLR_B) & match_b) |
                        ((cclr == CCLR_PIN) & xrst_rise);

  // Clear wins over a counter write, which wins over counting
  wire [7:0] cnt_d = clr_evt ? CNT_RST :
                     wr_cnt  ? wdata_q :
                     count_en ? cnt_q + 8'h01 : cnt_q;

  // A trigger beats a same-cycle halt so a start is never lost
  wire       run_d = trig_evt ? 1'b1 :
                     (clr_evt & gate_q) ? 1'b0 : run_q;

  wire [2:0] flag_set = {match_b, match_a, wrap};
  // Zero written to an armed flag clears it; a one is ignored
  wire [2:0] flag_clr = (wr_stat ? ~wdata_q[FLAG_HI:FLAG_LO] : 3'h0) &
                        armed_q;
  // Hardware set wins over a clear in the same cycle
  wire [2:0] flags_d  = (flags_q & ~flag_clr) | flag_set;
  wire [2:0] armed_d  = (armed_q & ~flag_clr) |
                        (rd_stat ? flags_q : 3'h0);

  wire       wave_d   = wave_next(wave_q, match_a, os_q[OS_A_HI:OS_A_LO],
                                  match_b, os_q[OS_B_HI:OS_B_LO]);

  assign waveform_pin = wave_q;
  assign irq          = |(flags_q & ctrl0_q[IEN_HI:IEN_LO]);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q    <= '0;
      sync2_q    <= '0;
      pin_prev_q <= '0;
    end else if (ce) begin
      sync1_q    <= {ext_reset_pin, ext_clk_pin, trigger_pin};
      sync2_q    <= sync1_q;
      pin_prev_q <= sync2_q;
    end
  end

  // ---------------------------------------------------------------
  // Timer state
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= CNT_RST;
      wave_q  <= 1'b0;
      run_q   <= 1'b0;
    end else if (ce) begin
      cnt_q   <= cnt_d;
      wave_q  <= wave_d;
      run_q   <= run_d;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Only a read that saw a flag set arms its clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
      armed_q <= '0;
    end else if (ce) begin
      flags_q <= flags_d;
      armed_q <= armed_d;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q <= CTRL0_RST;
      os_q    <= '0;
      edge_q  <= EDGE_OFF;
      gate_q  <= 1'b0;
      xclk_q  <= 1'b0;
      cmp_a_q <= CMP_RST;
      cmp_b_q <= CMP_RST;
    end else if (ce) begin
      if (wr_ctrl0) begin
        ctrl0_q <= wdata_q;
      end
      if (wr_stat) begin
        os_q <= wdata_q[OS_B_HI:OS_A_LO];
      end
      if (wr_trig) begin
        edge_q <= wdata_q[TEDGE_HI:TEDGE_LO];
        gate_q <= wdata_q[TGATE];
        xclk_q <= wdata_q[XCLK_BIT];
      end
      if (wr_cmp_a) begin
        cmp_a_q <= wdata_q;
      end
      if (wr_cmp_b) begin
        cmp_b_q <= wdata_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= '0;
      w_hold_q  <= 1'b0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (ce) begin
      // Address and data beats may come in either order
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= is_mapped(awaddr_q) ? RESP_OKAY :
                                           RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ce) begin
      // Data is captured with the address and held until rready
      if (ar_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h000000, rd_mux};
        rresp_q  <= is_mapped(s_axi_araddr) ? RESP_OKAY :
                                              RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import tst_pkg::*;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce      = 1'b1;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [3:0]  wstrb   = 4'h1;
  wire logic   awready, wready, bvalid, arready, rvalid, wave, irq, trig, xclk, xrst;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  logic [31:0] rv;
  logic [1:0]  rs;
  int          errors    = 0;
  int          cmp_count = 0;
  localparam logic [7:0] RST [6] = '{8'h00, 8'h10, 8'he2, 8'h00, 8'hff, 8'hff};
  // Rows: address, write value, read-back value, response
  localparam logic [25:0] ROWS [10] = '{
    {OFS_TRIG, 8'h19, 8'hfb, RESP_OKAY}, {OFS_TRIG, 8'h08, 8'hea, RESP_OKAY},
    {OFS_TRIG, 8'h10, 8'hf2, RESP_OKAY}, {OFS_TRIG, 8'h00, 8'he2, RESP_OKAY},
    {OFS_STATUS, 8'hef, 8'h1f, RESP_OKAY}, {OFS_STATUS, 8'h00, 8'h10, RESP_OKAY},
    {OFS_CMP_A, 8'h5a, 8'h5a, RESP_OKAY}, {OFS_CMP_B, 8'ha5, 8'ha5, RESP_OKAY},
    {OFS_CTRL_ZERO, 8'he0, 8'he0, RESP_OKAY}, {8'h20, 8'h3c, 8'h00, RESP_SLVERR}};

  always #12.5 aclk = ~aclk;

  tst_top u_tst_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trigger_pin(trig), .ext_clk_pin(xclk),
    .ext_reset_pin(xrst), .waveform_pin(wave), .irq(irq));
  tst_pin_model u_tst_pin_model (.aclk(aclk), .trigger_pin(trig), .ext_clk_pin(xclk),
    .ext_reset_pin(xrst));

  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo;
    errors++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // ---------------------------------------------------------------
  // Bus cycles: ready is sampled at the falling edge, acted on at the rise
  // ---------------------------------------------------------------
  task automatic wrc(input logic [7:0] a, input logic [7:0] v,
                     input logic [1:0] re = RESP_OKAY);
    int   n;
    logic ha, hw, hb;
    awaddr  <= a;
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    hb = 1'b0;
    for (n = 0; n < 40 && !hb; n++) begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    if (!hb) tmo();
    chk({30'h0, rs}, {30'h0, re}, "write resp");
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input logic [1:0] re = RESP_OKAY);
    int   n;
    logic ha, hr;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    hr = 1'b0;
    for (n = 0; n < 40 && !hr; n++) begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    if (!hr) tmo();
    chk(rv, {24'h0, e}, "read data");
    chk({30'h0, rs}, {30'h0, re}, "read resp");
    @(posedge aclk);
  endtask
  task automatic pins(input logic w, input logic q, input string m);
    @(negedge aclk);
    chk({30'h0, wave, irq}, {30'h0, w, q}, m);
    @(posedge aclk);
  endtask
  task automatic wait_pin(input logic s, input logic l);
    int   n;
    logic hit;
    cmp_count++;
    hit = 1'b0;
    for (n = 0; n < 400 && !hit; n++) begin
      @(negedge aclk);
      hit = ((s ? irq : wave) === l);
    end
    if (!hit) tmo();
    @(posedge aclk);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    pins(1'b0, 1'b0, "after reset");
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(8'(4 * i), RST[i]);
    for (int i = 0; i < 10; i++) begin
      wrc(ROWS[i][25:18], ROWS[i][17:10], ROWS[i][1:0]);
      rdc(ROWS[i][25:18], ROWS[i][9:2], ROWS[i][1:0]);
    end
    // Wrap, enabled interrupt, and the read-then-write-0 clearing
    wrc(OFS_COUNTER, 8'hfd);
    wrc(OFS_CTRL_ZERO, 8'h21);
    wait_pin(1'b1, 1'b1);
    wrc(OFS_STATUS, 8'h00);
    rdc(OFS_STATUS, 8'h30);
    wrc(OFS_STATUS, 8'h20);
    rdc(OFS_STATUS, 8'h30);
    wrc(OFS_STATUS, 8'h00);
    rdc(OFS_STATUS, 8'h10);
    pins(1'b0, 1'b0, "flag cleared");
    // Match A drives high, match B drives low; interrupts masked
    wrc(OFS_CTRL_ZERO, 8'h00);
    wrc(OFS_COUNTER, 8'h00);
    wrc(OFS_CMP_A, 8'h02);
    wrc(OFS_CMP_B, 8'h04);
    wrc(OFS_STATUS, 8'h06);
    wrc(OFS_CTRL_ZERO, 8'h01);
    wait_pin(1'b0, 1'b1);
    wait_pin(1'b0, 1'b0);
    wrc(OFS_CTRL_ZERO, 8'h00);
    rdc(OFS_STATUS, 8'hd6);
    pins(1'b0, 1'b0, "masked flags");
    // Same-cycle matches: toggle must beat drive-low
    wrc(OFS_COUNTER, 8'h00);
    wrc(OFS_CMP_A, 8'h03);
    wrc(OFS_CMP_B, 8'h03);
    wrc(OFS_STATUS, 8'h07);
    wrc(OFS_CTRL_ZERO, 8'h01);
    wait_pin(1'b0, 1'b1);
    // Gated start on the falling trigger edge only, counted on pin edges
    wrc(OFS_CTRL_ZERO, 8'h00);
    wrc(OFS_COUNTER, 8'h00);
    wrc(OFS_TRIG, 8'h14);
    wrc(OFS_CTRL_ZERO, {5'h00, CKS_XRISE});
    u_tst_pin_model.trig_lvl(1'b1);
    u_tst_pin_model.ext_edges(2);
    rdc(OFS_COUNTER, 8'h00);
    u_tst_pin_model.trig_lvl(1'b0);
    repeat (8) @(posedge aclk);
    u_tst_pin_model.ext_edges(3);
    rdc(OFS_COUNTER, 8'h03);
    chk({31'h0, rv[7:0] != 8'h00}, 32'h1, "count after trigger");
    // External rising edges counted one for one
    wrc(OFS_TRIG, 8'h00);
    wrc(OFS_CTRL_ZERO, 8'h00);
    wrc(OFS_COUNTER, 8'h00);
    wrc(OFS_CTRL_ZERO, {5'h00, CKS_XRISE});
    u_tst_pin_model.ext_edges(5);
    repeat (8) @(posedge aclk);
    rdc(OFS_COUNTER, 8'h05);
    // Pin clear with gating on halts the count
    wrc(OFS_TRIG, 8'h0c);
    wrc(OFS_CTRL_ZERO, 8'h1d);
    u_tst_pin_model.xrst_pulse();
    u_tst_pin_model.ext_edges(2);
    rdc(OFS_COUNTER, 8'h00);
    // A write without byte lane 0 has no effect
    wstrb <= 4'h0;
    wrc(OFS_CMP_A, 8'h77);
    rdc(OFS_CMP_A, 8'h03);
    end_sim();
  end
endmodule

/* File: verif/tst_pin_model.sv */
`timescale 1ns/1ps
module tst_pin_model (
  input  wire logic aclk,
  output logic      trigger_pin,
  output logic      ext_clk_pin,
  output logic      ext_reset_pin
);
  initial begin
    trigger_pin   = 1'b0;
    ext_clk_pin   = 1'b0;
    ext_reset_pin = 1'b0;
  end

  task automatic xrst_pulse;
    @(posedge aclk);
    ext_reset_pin <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_reset_pin <= 1'b0;
  endtask

  // Level set at the next edge; the caller holds it
  task automatic trig_lvl(input logic l);
    @(posedge aclk);
    trigger_pin <= l;
  endtask

  // Clock stands still between bursts, as a real source would
  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge aclk);
      ext_clk_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_clk_pin <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask
endmodule

/* File: verif/tst_top_asserts.sv */
`timescale 1ns/1ps
module tst_chk
  import tst_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        waveform_pin,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address of the read in flight, so read data can be judged
  logic [7:0] ra_q;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end

  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !waveform_pin && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not quiet after reset");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_ce_stall: assert property (!ce |-> !s_axi_awready && !s_axi_wready
    && !s_axi_arready) else $error("ready while stalled");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_status_rsv: assert property (s_axi_rvalid && ra_q == OFS_STATUS |->
    s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[ST_RSV]) else $error("status bit 4 low");
  a_trig_rsv: assert property (s_axi_rvalid && ra_q == OFS_TRIG |->
    s_axi_rdata[7:5] == 3'h7 && s_axi_rdata[1]) else $error("trigger reserved low");
  a_unmapped_err: assert property (s_axi_rvalid && ra_q > OFS_CMP_B |->
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_irq: cover property ($rose(irq));
  c_wave: cover property ($rose(waveform_pin));
endmodule

bind tst_top tst_chk u_tst_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .waveform_pin(waveform_pin), .irq(irq));
